// ### hdl/limit_tracker.sv
`timescale 1ns/10ps
`include "sensor_regs.svh"
module limit_tracker
   import sensor_pkg::*;
#(
   parameter int WIDTH = 13
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Finished sample and limits, all sign-extended
   input  wire logic             sample_done,
   input  wire logic [WIDTH-1:0] sample,
   input  wire logic [WIDTH-1:0] lower,
   input  wire logic [WIDTH-1:0] upper,
   input  wire logic [1:0]       fault_sel,
   // Comparator status, high while over the limit
   output logic                  over
);
   logic [2:0] run;
   logic [2:0] needed;
   wire        hot  = $signed(sample) >= $signed(upper);
   wire        cold = $signed(sample) <  $signed(lower);
   wire        fault = over ? cold : hot;

   // Consecutive-fault count per fault select code
   assign needed = (fault_sel == 2'h0) ? 3'h1 :
                   (fault_sel == 2'h1) ? 3'h2 :
                   (fault_sel == 2'h2) ? 3'h4 : 3'h6;   // R22

   // A good sample breaks the run, so faults must be back to back
   always_ff @(posedge clk) begin
      if (reset) begin
         run  <= 3'h0;
         over <= 1'b0;
      end else if (sample_done) begin
         if (!fault) begin
            run <= 3'h0;
         end else if (run + 3'h1 >= needed) begin
            run  <= 3'h0;
            over <= ~over;                                // R14
         end else begin
            run <= run + 3'h1;
         end
      end
   end
endmodule

// ### hdl/sensor_pkg.sv
package sensor_pkg;
   // One register access from the serial front end
   typedef struct packed {
      logic       write;     // Write one data byte
      logic       index_wr;  // Write index register
      logic       first;     // Byte is the most significant one
      logic [7:0] data;
   } reg_access_t;

   typedef enum logic [3:0] {
      CONVERTING = 4'b0001,
      WAITING    = 4'b0010,
      HALTED     = 4'b0100,
      SINGLE     = 4'b1000
   } conv_state_t;
endpackage

// ### hdl/sensor_regs.svh
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH
// Register indices (two low bits of the index register)
`define IDX_RESULT       2'h0
`define IDX_CONFIG       2'h1
`define IDX_LOWER        2'h2
`define IDX_UPPER        2'h3
// Reset values
`define CONFIG_RESET     16'h60A0
`define LOWER_RESET      16'h4B00
`define UPPER_RESET      16'h5000
// Configuration field positions
`define CFG_SHOT         15
`define CFG_RES_HI       14
`define CFG_RES_LO       13
`define CFG_FAULT_HI     12
`define CFG_FAULT_LO     11
`define CFG_INVERT       10
`define CFG_THERMO       9
`define CFG_HALT         8
`define CFG_RATE_HI      7
`define CFG_RATE_LO      6
`define CFG_FLAG         5
`define CFG_WIDE         4
// Writable bits of each configuration byte
`define CFG_WMASK_HI     8'h1F
`define CFG_WMASK_LO     8'hD0
// Timing
`define CONV_TIME_MS     26
`define CLK_MHZ          100
`define PERIOD_025HZ_MS  4000
`define PERIOD_1HZ_MS    1000
`define PERIOD_4HZ_MS    250
`define PERIOD_8HZ_MS    125
`define CYC_PER_MS       (`CLK_MHZ * 1000)
`endif

// ### hdl/temp_sensor_registers.sv
`timescale 1ns/10ps
`include "sensor_regs.svh"
// How it works
// R01: An 8-bit index register; its low two bits choose the data register.
// R02: Master writes zeros into index bits 7..2.
// R03: Index 0 result (read-only), 1 config, 2 lower, 3 upper limit.
// R04: Index select bits reset to 00, so reads give the result.
// R05: Result keeps latest conversion, 12 bits normal, 13 bits wide.
// R06: Result sent MSB first, left-justified; master may stop after byte one.
// R07: 0.0625 C per count, two's complement, sign in top bit.
// R08: Result reads zero until the first conversion after reset completes.
// R09: Bit 0 of the low result byte mirrors the wide-format select.
// R10: Result bits without temperature data read zero.
// R11: Config is 16-bit, MSB first; registers update byte by byte.
// R12: Config field layout with reset value 0x60A0.
// R13: Wide format makes result and both limits 13-bit.
// R14: Limit flag reads 1 until enough hot samples, then 0 until cold.
// R15: Output sense invert flips the limit flag readback.
// R16: Limit flag follows comparator behaviour whatever the thermostat bit.
// R17: Rate select: 00 0.25Hz, 01 1Hz, 10 4Hz default, 11 8Hz.
// R18: Each period is one 26 ms conversion then idle to period end.
// R19: After reset a conversion starts at once; result 26 ms later.
// R20: Halt bit finishes current conversion then stops; else continuous.
// R21: While halted, single-shot starts one conversion, reads 0 then 1.
// R22: Fault select 00/01/10/11 needs 1/2/4/6 consecutive faults.
// R23: Writes to the result and read-only config bits are ignored.
module temp_sensor_registers
   import sensor_pkg::*;
#(
   parameter int CONV_CYCLES = `CONV_TIME_MS * `CYC_PER_MS,
   parameter int MS_CYCLES   = `CYC_PER_MS
) (
   // Clock and reset (reset also serves general-call reset)
   input  wire logic        clk,
   input  wire logic        reset,
   // Register access from the serial front end
   input  wire reg_access_t acc,
   // Byte offered for the next read, first or second byte
   input  wire logic        rd_first,
   output logic [7:0]       rd_data,
   // Raw sensor sample, 13-bit two's complement
   input  wire logic [12:0] sensor_value,
   // State visible for system use
   output logic [7:0]       index_reg,
   output logic             converting
);
   localparam int PERIOD_025 = `PERIOD_025HZ_MS;
   localparam int PERIOD_1   = `PERIOD_1HZ_MS;
   localparam int PERIOD_4   = `PERIOD_4HZ_MS;
   localparam int PERIOD_8   = `PERIOD_8HZ_MS;

   logic [15:0] config_reg;
   logic [15:0] lower_limit;
   logic [15:0] upper_limit;
   logic [12:0] result;
   logic [31:0] cycle_cnt;
   logic [12:0] next_result;
   logic        shot_done;
   conv_state_t state;
   logic        over;

   // Decoded configuration fields
   wire         wide     = config_reg[`CFG_WIDE];
   wire         halt     = config_reg[`CFG_HALT];
   wire         invert   = config_reg[`CFG_INVERT];
   wire  [1:0]  rate     = {config_reg[`CFG_RATE_HI],
                            config_reg[`CFG_RATE_LO]};
   wire  [1:0]  fault    = {config_reg[`CFG_FAULT_HI],
                            config_reg[`CFG_FAULT_LO]};
   wire  [1:0]  sel      = index_reg[1:0];                // R01

   // Period length in milliseconds for the selected rate
   wire  [31:0] period_ms = (rate == 2'h0) ? PERIOD_025 :
                            (rate == 2'h1) ? PERIOD_1   :
                            (rate == 2'h2) ? PERIOD_4   : PERIOD_8; // R17
   // Count runs from conversion start; >= ends a wait cut short by a rate
   wire  [31:0] period_cyc = 32'(period_ms * MS_CYCLES);          // R18
   wire         conv_end  = (state == CONVERTING || state == SINGLE) &&
                            (cycle_cnt == 32'(CONV_CYCLES - 1));
   wire         period_end = (state == WAITING) &&
                             (cycle_cnt + 32'h1 >= period_cyc);

   // Normal format keeps 12 bits at the same weight, so samples beyond
   // its range clip to the end values; stored sign-extended to 13 bits
   assign next_result = wide ? sensor_value :
      ((sensor_value[12] != sensor_value[11]) ?
         {sensor_value[12], sensor_value[12], {11{~sensor_value[12]}}} :
         sensor_value);                                   // R05 R07 R13

   // Limits sign-extended to 13 bits from the active format
   wire  [12:0] lower_13 = wide ? lower_limit[15:3] :
                           {lower_limit[15], lower_limit[15:4]};  // R13
   wire  [12:0] upper_13 = wide ? upper_limit[15:3] :
                           {upper_limit[15], upper_limit[15:4]};

   // Left-justified result; unused positions zero, D0 shows format
   wire  [15:0] result_word = wide ? {result, 2'b00, 1'b1} :
                              {result[11:0], 4'h0};       // R06 R09 R10

   // Flag reads 1 when not over; invert flips it
   wire         flag = ~over ^ invert;                    // R14 R15 R16
   wire         shot_rd = shot_done && (state != SINGLE); // R21
   wire  [15:0] config_rd = {shot_rd, config_reg[14:6], flag,
                             config_reg[4:0]};

   // Read multiplexer, most significant byte first
   wire  [15:0] rd_word = (sel == `IDX_RESULT) ? result_word :
                          (sel == `IDX_CONFIG) ? config_rd   :
                          (sel == `IDX_LOWER)  ? lower_limit :
                                                 upper_limit; // R03
   wire  [7:0]  next_rd = rd_first ? rd_word[15:8] : rd_word[7:0]; // R06

   wire         wr_byte = acc.write && !acc.index_wr;
   wire         shot_go = wr_byte && acc.first && sel == `IDX_CONFIG &&
                          acc.data[7] && state == HALTED;

   assign converting = (state == CONVERTING) || (state == SINGLE);

   // Index register; high bits kept as written, zero by protocol
   always_ff @(posedge clk) begin
      if (reset) begin
         index_reg <= 8'h00;                              // R04
      end else if (acc.write && acc.index_wr) begin
         index_reg <= acc.data;                           // R01 R02
      end
   end

   // Byte-wide register updates as each byte arrives
   always_ff @(posedge clk) begin
      if (reset) begin
         config_reg  <= `CONFIG_RESET;                    // R12
         lower_limit <= `LOWER_RESET;
         upper_limit <= `UPPER_RESET;
      end else if (wr_byte) begin                         // R11
         case (sel)
            `IDX_CONFIG: begin
               // Read-only bits keep their stored values
               if (acc.first) begin
                  config_reg[15:8] <= (config_reg[15:8] & ~`CFG_WMASK_HI) |
                                      (acc.data & `CFG_WMASK_HI); // R23
               end else begin
                  config_reg[7:0] <= (config_reg[7:0] & ~`CFG_WMASK_LO) |
                                     (acc.data & `CFG_WMASK_LO);  // R23
               end
            end
            `IDX_LOWER: begin
               if (acc.first) lower_limit[15:8] <= acc.data;
               else           lower_limit[7:0]  <= acc.data;
            end
            `IDX_UPPER: begin
               if (acc.first) upper_limit[15:8] <= acc.data;
               else           upper_limit[7:0]  <= acc.data;
            end
            default: ;                                    // R23
         endcase
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state     <= CONVERTING;                         // R19
         cycle_cnt <= 32'h0;
         result    <= 13'h0000;                           // R08
      end else begin
         cycle_cnt <= cycle_cnt + 32'h1;
         case (state)
            CONVERTING: begin
               if (conv_end) begin
                  result <= next_result;                  // R05 R18
                  state  <= halt ? HALTED : WAITING;      // R20
               end
            end
            WAITING: begin
               if (halt) begin
                  state <= HALTED;                        // R20
               end else if (period_end) begin
                  cycle_cnt <= 32'h0;
                  state     <= CONVERTING;                // R18
               end
            end
            HALTED: begin
               cycle_cnt <= 32'h0;
               if (shot_go) begin
                  state <= SINGLE;                        // R21
               end else if (!halt) begin
                  state <= CONVERTING;                    // R20
               end
            end
            SINGLE: begin
               if (conv_end) begin
                  result <= next_result;
                  state  <= HALTED;                       // R21
               end
            end
            default: state <= CONVERTING;
         endcase
      end
   end

   // Read byte register
   always_ff @(posedge clk) begin
      if (reset) rd_data <= 8'h00;
      else       rd_data <= next_rd;
   end

   // Ready mark, clear from reset and during a single conversion; kept
   // apart from config_reg so that a config write cannot fake it
   always_ff @(posedge clk) begin
      if (reset) begin
         shot_done <= 1'b0;
      end else if (shot_go) begin
         shot_done <= 1'b0;                               // R21
      end else if (state == SINGLE && conv_end) begin
         shot_done <= 1'b1;                               // R21
      end
   end

   // Comparator status over finished samples
   limit_tracker #(
      .WIDTH      (13)
   ) u_tracker (
      .clk         (clk),
      .reset       (reset),
      .sample_done (conv_end),
      .sample      (next_result),
      .lower       (lower_13),
      .upper       (upper_13),
      .fault_sel   (fault),
      .over        (over)
   );

   // Assertions
   property p_index_reset;
      @(posedge clk) reset |=> index_reg == 8'h00;
   endproperty
   a_index_reset: assert property (p_index_reset)   // R04
      else $error("index not cleared by reset");

   property p_result_zero;
      @(posedge clk) reset |=> result == 13'h0 && converting;
   endproperty
   a_result_zero: assert property (p_result_zero)   // R08 R19
      else $error("no zero result or no conversion after reset");

   property p_result_ro;
      @(posedge clk) disable iff (reset)
      (wr_byte && sel == `IDX_RESULT && !conv_end) |=> $stable(result);
   endproperty
   a_result_ro: assert property (p_result_ro)       // R23
      else $error("result changed by a write");

   property p_format_bit;
      @(posedge clk) disable iff (reset)
      sel == `IDX_RESULT && !rd_first |=> rd_data[0] == $past(wide);
   endproperty
   a_format_bit: assert property (p_format_bit)     // R09
      else $error("format bit wrong");

   property p_unused_zero;
      @(posedge clk) disable iff (reset)
      sel == `IDX_RESULT && !rd_first && !wide |=> rd_data[3:0] == 4'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)   // R10
      else $error("unused result bits not zero");

   property p_halt_stops;
      @(posedge clk) disable iff (reset)
      state == WAITING && halt |=> state == HALTED;
   endproperty
   a_halt_stops: assert property (p_halt_stops)     // R20
      else $error("halt did not stop conversions");

   sequence s_shot_start;
      shot_go;
   endsequence
   sequence s_shot_busy;
      state == SINGLE && config_rd[`CFG_SHOT] == 1'b0;
   endsequence
   property p_single_shot;
      @(posedge clk) disable iff (reset) s_shot_start |=> s_shot_busy;
   endproperty
   a_single_shot: assert property (p_single_shot)   // R21
      else $error("single shot did not start");

   property p_conv_done;
      @(posedge clk) disable iff (reset)
      conv_end |=> result == $past(next_result);
   endproperty
   a_conv_done: assert property (p_conv_done)       // R05
      else $error("result not loaded at conversion end");

   property p_flag_invert;
      @(posedge clk) disable iff (reset)
      config_rd[`CFG_FLAG] == (~over ^ invert);
   endproperty
   a_flag_invert: assert property (p_flag_invert)   // R15
      else $error("flag polarity wrong");

   // A period ends by starting the next conversion from a fresh count
   property p_period_restart;
      @(posedge clk) disable iff (reset)
      period_end && !halt |=> state == CONVERTING && cycle_cnt == 32'h0;
   endproperty
   a_period_restart: assert property (p_period_restart)   // R18
      else $error("next conversion did not start at period end");

   sequence s_shot_end;
      state == SINGLE && conv_end;
   endsequence
   property p_shot_ready;
      @(posedge clk) disable iff (reset)
      s_shot_end |=> state == HALTED && config_rd[`CFG_SHOT];
   endproperty
   a_shot_ready: assert property (p_shot_ready)           // R21
      else $error("single shot did not end halted with ready mark");
endmodule

// ### verification/bus_master_model.sv
`timescale 1ns/10ps
module bus_master_model
   import sensor_pkg::*;
(
   // Clock
   input  wire logic   clk,
   // Register access towards the device
   output reg_access_t acc,
   output logic        rd_first,
   // One-cycle mark that rd_data is due for checking
   output logic        rd_take
);
   // Idle bus at time zero, no byte offered
   initial begin
      acc      = '0;
      rd_first = 1'b1;
      rd_take  = 1'b0;
   end

   // One written byte, a single-cycle pulse just after the edge
   task automatic put_byte(input logic iw, input logic fst,
                           input logic [7:0] b);
      @(posedge clk);
      #1;
      acc = '{write: 1'b1, index_wr: iw, first: fst, data: b};
      @(posedge clk);
      #1;
      acc = '0;
   endtask

   // Upper index bits always sent as zero
   task automatic set_index(input logic [1:0] idx);
      put_byte(1'b1, 1'b0, {6'h00, idx});
   endtask

   // Most significant byte goes first, each byte lands on its own
   task automatic write_reg(input logic [1:0] idx, input logic [15:0] v);
      set_index(idx);
      put_byte(1'b0, 1'b1, v[15:8]);
      put_byte(1'b0, 1'b0, v[7:0]);
   endtask

   // Select a byte, give rd_data two edges to settle, then mark it
   task automatic read_byte(input logic fst);
      @(posedge clk);
      #1;
      rd_first = fst;
      repeat (2) @(posedge clk);
      #1;
      rd_take = 1'b1;
      @(posedge clk);
      #1;
      rd_take = 1'b0;
   endtask
endmodule

// ### verification/temp_sensor_registers_tb.sv
`timescale 1ns/10ps
module temp_sensor_registers_tb
   import sensor_pkg::*;
();
   localparam int CONV = 50;
   localparam int MSC  = 5;
   logic        clk;
   logic        reset;
   reg_access_t acc;
   logic        rd_first;
   logic        rd_take;
   logic [7:0]  rd_data;
   logic [12:0] sensor_value;
   logic [7:0]  index_reg;
   logic        converting;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          n;
   int          m;
   int          ms_tab [4] = '{4000, 1000, 250, 125};
   logic [7:0]  exp_q [$];
   logic [12:0] v;

   // Short conversion and millisecond counts keep the run brief
   temp_sensor_registers #(.CONV_CYCLES(CONV), .MS_CYCLES(MSC))
      i_temp_sensor_registers (.clk(clk), .reset(reset), .acc(acc),
      .rd_first(rd_first), .rd_data(rd_data),
      .sensor_value(sensor_value), .index_reg(index_reg),
      .converting(converting));

   bus_master_model i_bus_master_model (.clk(clk), .acc(acc),
      .rd_first(rd_first), .rd_take(rd_take));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic timeout();
      error_cnt++;
      $display("unexpected wait: expected conversion edge, seen none");
      test_done();
   endtask

   // Notes the expected bytes, then lets the master fetch them
   task automatic read_reg(input logic [1:0] idx, input logic [15:0] e,
                           input logic both);
      i_bus_master_model.set_index(idx);
      exp_q.push_back(e[15:8]);
      i_bus_master_model.read_byte(1'b1);
      if (both) begin
         exp_q.push_back(e[7:0]);
         i_bus_master_model.read_byte(1'b0);
      end
   endtask

   // Cycles until the next start of a conversion
   task automatic wait_rise(input int lim, output int c);
      c = 0;
      while (converting !== 1'b0 && c < lim) begin
         @(posedge clk);
         #2;
         c++;
      end
      while (converting !== 1'b1 && c < lim) begin
         @(posedge clk);
         #2;
         c++;
      end
      if (c >= lim) timeout();
   endtask

   // Waits for a conversion to finish; c is how long it stayed high
   task automatic conv_end(output int c);
      int k;
      k = 0;
      c = 0;
      while (converting !== 1'b1 && k < 50000) begin
         @(posedge clk);
         #2;
         k++;
      end
      while (converting === 1'b1 && c < 1000) begin
         @(posedge clk);
         #2;
         c++;
      end
      if (k >= 50000 || c >= 1000) timeout();
   endtask

   // Halted device must show no conversion activity for a while
   task automatic quiet_check();
      n = 0;
      repeat (2000) begin
         @(posedge clk);
         #2;
         if (converting !== 1'b0) n++;
      end
      check("halted activity", 16'(n), 16'h0000);
   endtask

   // Every marked read byte is matched to the oldest note
   always @(posedge clk) begin
      if (rd_take === 1'b1) begin
         if (exp_q.size() == 0)
            check("read queue", 16'h0001, 16'h0000);
         else
            check("rd_data", {8'h00, rd_data}, {8'h00, exp_q.pop_front()});
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'h13393bd7));
      reset = 1'b1;
      sensor_value = 13'h1E70;
      repeat (3) @(posedge clk);
      #1;
      reset = 1'b0;
      @(posedge clk);
      #2;
      check("converting", {15'h0, converting}, 16'h0001);
      check("index_reg", {8'h00, index_reg}, 16'h0000);
      exp_q.push_back(8'h00);
      i_bus_master_model.read_byte(1'b1);
      read_reg(2'h1, 16'h60A0, 1'b1);
      read_reg(2'h2, 16'h4B00, 1'b1);
      read_reg(2'h3, 16'h5000, 1'b1);
      check("index_reg", {8'h00, index_reg}, 16'h0003);
      conv_end(n);
      // Minus 25 degrees in normal format, then a refused write
      read_reg(2'h0, 16'hE700, 1'b1);
      i_bus_master_model.write_reg(2'h0, 16'hFFFF);
      read_reg(2'h0, 16'hE700, 1'b0);
      i_bus_master_model.write_reg(2'h1, 16'h1AEF);
      read_reg(2'h1, 16'h7AE0, 1'b1);
      // Two consecutive hot samples clear the flag, two cold clear the inverted one
      i_bus_master_model.write_reg(2'h3, 16'h1900);
      i_bus_master_model.write_reg(2'h2, 16'h1400);
      i_bus_master_model.write_reg(2'h1, 16'h68C0);
      conv_end(n);
      sensor_value = 13'h01E0;
      conv_end(n);
      read_reg(2'h1, 16'h68E0, 1'b1);
      conv_end(n);
      read_reg(2'h1, 16'h68C0, 1'b1);
      i_bus_master_model.write_reg(2'h1, 16'h6CC0);
      read_reg(2'h1, 16'h6CE0, 1'b1);
      conv_end(n);
      sensor_value = 13'h1E70;
      conv_end(n);
      read_reg(2'h1, 16'h6CE0, 1'b1);
      conv_end(n);
      read_reg(2'h1, 16'h6CC0, 1'b1);
      // Halt, then one triggered conversion
      i_bus_master_model.write_reg(2'h1, 16'h61C0);
      quiet_check();
      i_bus_master_model.write_reg(2'h1, 16'hE1C0);
      read_reg(2'h1, 16'h6100, 1'b0);
      conv_end(n);
      read_reg(2'h1, 16'hE100, 1'b0);
      quiet_check();
      // Wide format with random samples
      i_bus_master_model.write_reg(2'h1, 16'h60D0);
      conv_end(n);
      repeat (4) begin
         v = 13'($urandom);
         sensor_value = v;
         conv_end(n);
         read_reg(2'h0, {v, 3'b001}, 1'b1);
      end
      // Every rate code; the 0.25 Hz one dominates the run time
      for (int r = 3; r >= 0; r--) begin
         i_bus_master_model.write_reg(2'h1, {8'h60, r[1:0], 6'h00});
         wait_rise(60000, n);
         conv_end(m);
         wait_rise(60000, n);
         check("conversion length",
               {15'h0, (m >= CONV - 1 && m <= CONV + 1)}, 16'h1);
         check("rate period", {15'h0, (n + m >= ms_tab[r] * MSC - 3 &&
               n + m <= ms_tab[r] * MSC + 3)}, 16'h1);
      end
      test_done();
   end
endmodule
